//--- rtl/sptm_consts.vh
// Register offsets, field positions, reset values and divider counts of the split timer block
`ifndef SPTM_CONSTS_VH
`define SPTM_CONSTS_VH

`define SPTM_TCTL_OFF 8'h00
`define SPTM_TMODE_OFF 8'h04
`define SPTM_T0LO_OFF 8'h08
`define SPTM_T0HI_OFF 8'h0C
`define SPTM_T1LO_OFF 8'h10
`define SPTM_T1HI_OFF 8'h14
`define SPTM_CKC_OFF 8'h18
`define SPTM_IEN_OFF 8'h1C

`define SPTM_TCTL_RST 8'h00
`define SPTM_TMODE_RST 8'h00
`define SPTM_CNT_RST 8'h00
`define SPTM_CKC_RST 4'h0
`define SPTM_IEN_RST 4'h0

`define SPTM_OVF1_BIT 7
`define SPTM_RUN1_BIT 6
`define SPTM_OVF0_BIT 5
`define SPTM_RUN0_BIT 4
`define SPTM_XF1_BIT 3
`define SPTM_XT1_BIT 2
`define SPTM_XF0_BIT 1
`define SPTM_XT0_BIT 0

`define SPTM_GT1_BIT 7
`define SPTM_CT1_BIT 6
`define SPTM_M1_HI 5
`define SPTM_M1_LO 4
`define SPTM_GT0_BIT 3
`define SPTM_CT0_BIT 2
`define SPTM_M0_HI 1
`define SPTM_M0_LO 0

`define SPTM_MODE_13 2'h0
`define SPTM_MODE_16 2'h1
`define SPTM_MODE_RELOAD 2'h2
`define SPTM_MODE_SPLIT 2'h3

`define SPTM_CKC_T0SYS_BIT 0
`define SPTM_CKC_T1SYS_BIT 1
`define SPTM_CKC_SCA_HI 3
`define SPTM_CKC_SCA_LO 2

`define SPTM_IEN_EX0_BIT 0
`define SPTM_IEN_ET0_BIT 1
`define SPTM_IEN_EX1_BIT 2
`define SPTM_IEN_ET1_BIT 3

`define SPTM_DIV_SCA0 8'h0C
`define SPTM_DIV_SCA1 8'h04
`define SPTM_DIV_SCA2 8'h30
`define SPTM_DIV_SCA3 8'h08

`endif

//--- rtl/sptm_sync.v
// Two-flop pin synchroniser with falling-edge detection behind the second flop
`timescale 1ns/100ps
`default_nettype none
module sptm_sync #(
  parameter W = 4
) (
  input wire pclk,
  input wire presetn,
  input wire [W-1:0] pin_in,
  output wire [W-1:0] level_out,
  output wire [W-1:0] fall_out
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;
  reg [W-1:0] last_r;

  // Pins idle high, so reset to ones avoids a false edge after release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= {W{1'b1}};
      sync_r <= {W{1'b1}};
      last_r <= {W{1'b1}};
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level_out = sync_r;
  assign fall_out = last_r & ~sync_r;
endmodule
`default_nettype wire

//--- rtl/sptm_prescale.v
// Prescaler: one-cycle enable pulse every div_in cycles of pclk
`timescale 1ns/100ps
`default_nettype none
module sptm_prescale (
  input wire pclk,
  input wire presetn,
  input wire [7:0] div_in,
  output reg tick_out
);
  reg [7:0] cnt_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
      tick_out <= 1'b0;
    end else if (cnt_r >= div_in - 8'h01) begin
      // A changed divisor below the count simply wraps here at once
      cnt_r <= 8'h00;
      tick_out <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- rtl/sptm_top.v
// Timer 0/1 pair with split mode, shared control register and APB register slave
// Functional notes
// R1: With the first timer in mode 3 its low and high bytes count as two separate 8-bit counters.
// R2: In split mode the low byte obeys the first timer's run, source, gate and overflow bits.
// R3: The split low byte counts the timebase or falling edges on its event pin, as selected.
// R4: The split high byte is a timer only, ticked by system or prescaled clock, never a pin.
// R5: The split high byte runs only while the second timer's run bit is set.
// R6: A split high byte overflow sets the second timer's overflow flag and so its interrupt.
// R7: The second timer stops counting when its own mode field is 3.
// R8: During split mode the second timer ignores its event pin and sets no flag or interrupt.
// R9: During split mode the second timer's overflow still goes out as baud tick and ADC trigger.
// R10: During split mode the second timer runs in modes 0 to 2 and stops in 3, whatever its run bit.
// R11: A counter overflow sets its overflow flag, which requests an interrupt when enabled.
// R12: A timer counts only with its run bit set and either gate clear or its irq pin high.
// R13: Overflow flags are software writable and clear when the core vectors to their handler.
// R14: External irq flags set on a falling edge or low level as typed; software may clear edge-typed flags, level-typed ones follow the pin.
`include "sptm_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module sptm_top #(
  parameter [7:0] DIV_SCA0 = `SPTM_DIV_SCA0,
  parameter [7:0] DIV_SCA1 = `SPTM_DIV_SCA1,
  parameter [7:0] DIV_SCA2 = `SPTM_DIV_SCA2,
  parameter [7:0] DIV_SCA3 = `SPTM_DIV_SCA3
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ext_irq0_pin_n,
  input wire ext_irq1_pin_n,
  input wire t0_event_pin,
  input wire t1_event_pin,
  input wire ack_t0,
  input wire ack_t1,
  input wire ack_ext0,
  input wire ack_ext1,
  output reg irq_t0,
  output reg irq_t1,
  output reg irq_ext0,
  output reg irq_ext1,
  output reg baud_tick,
  output reg adc_trig
);
  reg [7:0] timer_control_r;
  reg [7:0] timer_mode_reg_r;
  reg [7:0] first_timer_low_byte_r;
  reg [7:0] first_timer_high_byte_r;
  reg [7:0] second_low_r;
  reg [7:0] second_high_r;
  reg [3:0] ckc_r;
  reg [3:0] ien_r;
  reg [7:0] tctl_nxt;
  reg [7:0] t0lo_nxt;
  reg [7:0] t0hi_nxt;
  reg [7:0] tl1_nxt;
  reg [7:0] th1_nxt;
  reg ovf0;
  reg ovf0_hi;
  reg ovf1;
  reg [7:0] div_sel;
  reg [31:0] rd_nxt;
  reg rd_err;

  wire [3:0] pin_level;
  wire [3:0] pin_fall;
  wire pre_tick;

  // Bit order on the synchroniser: irq0, irq1, event0, event1
  sptm_sync #(
    .W(4)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({t1_event_pin, t0_event_pin, ext_irq1_pin_n, ext_irq0_pin_n}),
    .level_out(pin_level),
    .fall_out(pin_fall)
  );

  always @* begin
    case (ckc_r[`SPTM_CKC_SCA_HI:`SPTM_CKC_SCA_LO])
      2'h0: div_sel = DIV_SCA0;
      2'h1: div_sel = DIV_SCA1;
      2'h2: div_sel = DIV_SCA2;
      default: div_sel = DIV_SCA3;
    endcase
  end

  sptm_prescale u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .div_in(div_sel),
    .tick_out(pre_tick)
  );

  // Increment for modes 0..2: {overflow, high byte, low byte}
  function [16:0] sptm_inc;
    input [1:0] mode;
    input [15:0] val;
    reg [13:0] c13;
    reg [16:0] c16;
    reg [8:0] c8;
    begin
      c13 = {1'b0, val[15:8], val[4:0]} + 14'h0001;
      c16 = {1'b0, val} + 17'h00001;
      c8 = {1'b0, val[7:0]} + 9'h001;
      case (mode)
        `SPTM_MODE_13: sptm_inc = {c13[13], c13[12:5], val[7:5], c13[4:0]};
        `SPTM_MODE_16: sptm_inc = c16;
        default: sptm_inc = c8[8] ? {1'b1, val[15:8], val[15:8]} : {1'b0, val[15:8], c8[7:0]};
      endcase
    end
  endfunction

  wire [1:0] mode0 = timer_mode_reg_r[`SPTM_M0_HI:`SPTM_M0_LO];
  wire [1:0] mode1 = timer_mode_reg_r[`SPTM_M1_HI:`SPTM_M1_LO];
  wire first_timer_source_select = timer_mode_reg_r[`SPTM_CT0_BIT];
  wire first_timer_gate = timer_mode_reg_r[`SPTM_GT0_BIT];
  wire src1_sel = timer_mode_reg_r[`SPTM_CT1_BIT];
  wire gate1 = timer_mode_reg_r[`SPTM_GT1_BIT];
  wire first_timer_run = timer_control_r[`SPTM_RUN0_BIT];
  wire second_timer_run = timer_control_r[`SPTM_RUN1_BIT];
  wire split = (mode0 == `SPTM_MODE_SPLIT);
  wire base0_tick = ckc_r[`SPTM_CKC_T0SYS_BIT] | pre_tick;
  wire base1_tick = ckc_r[`SPTM_CKC_T1SYS_BIT] | pre_tick;

  // Gate is a level on the synchronised irq pin, so pulse width measurement lags two cycles
  wire run0 = first_timer_run & (~first_timer_gate | pin_level[0]); // [R12] [R2]
  wire tick0 = first_timer_source_select ? pin_fall[2] : base0_tick; // [R3]
  wire step0 = run0 & tick0;
  wire step0_hi = split & second_timer_run & base0_tick; // [R4] [R5]

  wire run1_norm = second_timer_run & (~gate1 | pin_level[1]); // [R12]
  wire run1 = (split ? 1'b1 : run1_norm) & (mode1 != `SPTM_MODE_SPLIT); // [R7] [R10]
  wire tick1 = (src1_sel & ~split) ? pin_fall[3] : base1_tick; // [R8]
  wire step1 = run1 & tick1;

  wire [16:0] inc0 = sptm_inc(mode0, {first_timer_high_byte_r, first_timer_low_byte_r});
  wire [16:0] inc1 = sptm_inc(mode1, {second_high_r, second_low_r});

  // Exact word match: unaligned or unmapped addresses select nothing
  function sptm_hit;
    input [7:0] a;
    input [7:0] off;
    begin
      sptm_hit = (a == off);
    end
  endfunction

  // Writes land only on the access edge, never in the setup cycle
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire wr_tctl = wr & sptm_hit(paddr, `SPTM_TCTL_OFF);
  wire wr_tmode = wr & sptm_hit(paddr, `SPTM_TMODE_OFF);
  wire wr_t0lo = wr & sptm_hit(paddr, `SPTM_T0LO_OFF);
  wire wr_t0hi = wr & sptm_hit(paddr, `SPTM_T0HI_OFF);
  wire wr_tl1 = wr & sptm_hit(paddr, `SPTM_T1LO_OFF);
  wire wr_th1 = wr & sptm_hit(paddr, `SPTM_T1HI_OFF);
  wire wr_ckc = wr & sptm_hit(paddr, `SPTM_CKC_OFF);
  wire wr_ien = wr & sptm_hit(paddr, `SPTM_IEN_OFF);

  always @* begin
    t0lo_nxt = first_timer_low_byte_r;
    t0hi_nxt = first_timer_high_byte_r;
    tl1_nxt = second_low_r;
    th1_nxt = second_high_r;
    ovf0 = 1'b0;
    ovf0_hi = 1'b0;
    ovf1 = 1'b0;
    if (split) begin
      if (step0) begin
        {ovf0, t0lo_nxt} = {1'b0, first_timer_low_byte_r} + 9'h001; // [R1] [R2]
      end
      if (step0_hi) begin
        {ovf0_hi, t0hi_nxt} = {1'b0, first_timer_high_byte_r} + 9'h001; // [R1] [R4]
      end
    end else if (step0) begin
      {ovf0, t0hi_nxt, t0lo_nxt} = inc0;
    end
    if (step1) begin
      {ovf1, th1_nxt, tl1_nxt} = inc1;
    end
    // A byte written by software replaces this cycle's count
    if (wr_t0lo) begin
      t0lo_nxt = pwdata[7:0];
    end
    if (wr_t0hi) begin
      t0hi_nxt = pwdata[7:0];
    end
    if (wr_tl1) begin
      tl1_nxt = pwdata[7:0];
    end
    if (wr_th1) begin
      th1_nxt = pwdata[7:0];
    end
  end

  // Flags: software write and vector acks first, hardware sets last so a set wins
  always @* begin
    tctl_nxt = timer_control_r;
    if (wr_tctl) begin
      tctl_nxt = pwdata[7:0]; // [R13] [R14]
    end
    if (ack_t0) begin
      tctl_nxt[`SPTM_OVF0_BIT] = 1'b0; // [R13]
    end
    if (ack_t1) begin
      tctl_nxt[`SPTM_OVF1_BIT] = 1'b0; // [R13]
    end
    // An ack on a level-typed flag is ignored, the pin decides
    if (ack_ext0 & timer_control_r[`SPTM_XT0_BIT]) begin
      tctl_nxt[`SPTM_XF0_BIT] = 1'b0;
    end
    if (ack_ext1 & timer_control_r[`SPTM_XT1_BIT]) begin
      tctl_nxt[`SPTM_XF1_BIT] = 1'b0;
    end
    if (ovf0) begin
      tctl_nxt[`SPTM_OVF0_BIT] = 1'b1; // [R11] [R2]
    end
    // In split mode only the high byte may raise the second flag
    if (split ? ovf0_hi : ovf1) begin
      tctl_nxt[`SPTM_OVF1_BIT] = 1'b1; // [R6] [R8] [R11]
    end
    // Level type makes the flag track the inverted pin; a software clear has no effect
    if (tctl_nxt[`SPTM_XT0_BIT]) begin
      if (pin_fall[0]) begin
        tctl_nxt[`SPTM_XF0_BIT] = 1'b1; // [R14]
      end
    end else begin
      tctl_nxt[`SPTM_XF0_BIT] = ~pin_level[0]; // [R14]
    end
    if (tctl_nxt[`SPTM_XT1_BIT]) begin
      if (pin_fall[1]) begin
        tctl_nxt[`SPTM_XF1_BIT] = 1'b1; // [R14]
      end
    end else begin
      tctl_nxt[`SPTM_XF1_BIT] = ~pin_level[1]; // [R14]
    end
  end

  always @* begin
    rd_err = 1'b0;
    rd_nxt = 32'h00000000;
    case (paddr)
      `SPTM_TCTL_OFF: rd_nxt = {24'h000000, timer_control_r};
      `SPTM_TMODE_OFF: rd_nxt = {24'h000000, timer_mode_reg_r};
      `SPTM_T0LO_OFF: rd_nxt = {24'h000000, first_timer_low_byte_r};
      `SPTM_T0HI_OFF: rd_nxt = {24'h000000, first_timer_high_byte_r};
      `SPTM_T1LO_OFF: rd_nxt = {24'h000000, second_low_r};
      `SPTM_T1HI_OFF: rd_nxt = {24'h000000, second_high_r};
      `SPTM_CKC_OFF: rd_nxt = {28'h0000000, ckc_r};
      `SPTM_IEN_OFF: rd_nxt = {28'h0000000, ien_r};
      default: rd_err = 1'b1;
    endcase
  end

  // Zero wait states: ready is raised in the setup cycle so the first access edge completes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel & ~penable) begin
      pready <= 1'b1;
      pslverr <= rd_err;
      prdata <= pwrite ? 32'h00000000 : rd_nxt;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control_r <= `SPTM_TCTL_RST;
      first_timer_low_byte_r <= `SPTM_CNT_RST;
      first_timer_high_byte_r <= `SPTM_CNT_RST;
      second_low_r <= `SPTM_CNT_RST;
      second_high_r <= `SPTM_CNT_RST;
    end else begin
      timer_control_r <= tctl_nxt;
      first_timer_low_byte_r <= t0lo_nxt;
      first_timer_high_byte_r <= t0hi_nxt;
      second_low_r <= tl1_nxt;
      second_high_r <= th1_nxt;
    end
  end

  // Configuration registers change only by software
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_reg_r <= `SPTM_TMODE_RST;
      ckc_r <= `SPTM_CKC_RST;
      ien_r <= `SPTM_IEN_RST;
    end else begin
      if (wr_tmode) begin
        timer_mode_reg_r <= pwdata[7:0];
      end
      if (wr_ckc) begin
        ckc_r <= pwdata[3:0];
      end
      if (wr_ien) begin
        ien_r <= pwdata[3:0];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_t0 <= 1'b0;
      irq_t1 <= 1'b0;
      irq_ext0 <= 1'b0;
      irq_ext1 <= 1'b0;
    end else begin
      irq_t0 <= timer_control_r[`SPTM_OVF0_BIT] & ien_r[`SPTM_IEN_ET0_BIT]; // [R11]
      irq_t1 <= timer_control_r[`SPTM_OVF1_BIT] & ien_r[`SPTM_IEN_ET1_BIT]; // [R11] [R6]
      irq_ext0 <= timer_control_r[`SPTM_XF0_BIT] & ien_r[`SPTM_IEN_EX0_BIT];
      irq_ext1 <= timer_control_r[`SPTM_XF1_BIT] & ien_r[`SPTM_IEN_EX1_BIT];
    end
  end

  // Tick outputs follow the second timer's carry in every mode, flag or no flag
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_tick <= 1'b0;
      adc_trig <= 1'b0;
    end else begin
      baud_tick <= ovf1; // [R9]
      adc_trig <= ovf1; // [R9]
    end
  end
endmodule
`default_nettype wire

//--- testbench/sptm_props.sv
// Checker on the bus and tick ports of the split timer block
`timescale 1ns/100ps
`default_nettype none
module sptm_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic baud_tick,
  input wire logic adc_trig
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic mapped = paddr <= 8'h1C && paddr[1:0] == 2'h0;
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready missing after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("pready held too long");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("pready outside access");
  property p_map; pready |-> pslverr == !mapped; endproperty
  a_map: assert property (p_map) else $error("pslverr wrong for address");
  property p_zero; !pready || pwrite |-> prdata == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("prdata not zero");
  property p_upper; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("read data above byte");
  property p_pair; baud_tick == adc_trig; endproperty
  a_pair: assert property (p_pair) else $error("baud and trigger differ");
  property p_pulse; baud_tick |=> !baud_tick; endproperty
  a_pulse: assert property (p_pulse) else $error("baud tick too long");
  c_err: cover property (pready && pslverr);
  c_rd: cover property (pready && !pwrite && prdata != 32'h0);
  c_tick: cover property (baud_tick);
endmodule
bind sptm_top sptm_props sptm_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .baud_tick(baud_tick), .adc_trig(adc_trig));
`default_nettype wire

//--- testbench/sptm_pins.sv
// Model of the event and interrupt pins outside the block
`timescale 1ns/100ps
`default_nettype none
module sptm_pins (
  input wire logic pclk,
  output logic ext_irq0_pin_n,
  output logic ext_irq1_pin_n,
  output logic t0_event_pin,
  output logic t1_event_pin
);
  logic [3:0] pins_r = 4'hF;
  assign {t1_event_pin, t0_event_pin, ext_irq1_pin_n, ext_irq0_pin_n} = pins_r;
  // Three cycles low and four high per pulse, above the two-cycle minimum the sampler needs
  task automatic falls(input int sel, input int n);
    repeat (n) begin
      @(posedge pclk) pins_r[sel] <= 1'b0;
      repeat (3) @(posedge pclk);
      pins_r[sel] <= 1'b1;
      repeat (3) @(posedge pclk);
    end
  endtask
  task automatic hold(input int sel, input logic v);
    @(posedge pclk) pins_r[sel] <= v;
  endtask
endmodule
`default_nettype wire

//--- testbench/split_timer_mode3_control_bench.sv
// Self-checking bench for the split timer block
`timescale 1ns/100ps
`default_nettype none
module split_timer_mode3_control_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] ack = 4'h0;
  wire [31:0] prdata;
  wire pready, pslverr, baud_tick, adc_trig;
  wire [3:0] pin, irq;
  int miscompares = 0;
  int cmp_count = 0;
  int ticks = 0;
  int t0;
  logic [31:0] q;
  logic [7:0] rv [4];
  logic [7:0] v8;
  sptm_pins sptm_pins_i (.pclk(pclk), .ext_irq0_pin_n(pin[0]), .ext_irq1_pin_n(pin[1]),
    .t0_event_pin(pin[2]), .t1_event_pin(pin[3]));
  sptm_top sptm_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq0_pin_n(pin[0]), .ext_irq1_pin_n(pin[1]),
    .t0_event_pin(pin[2]), .t1_event_pin(pin[3]), .ack_t0(ack[0]), .ack_t1(ack[1]),
    .ack_ext0(ack[2]), .ack_ext1(ack[3]), .irq_t0(irq[0]), .irq_t1(irq[1]),
    .irq_ext0(irq[2]), .irq_ext1(irq[3]), .baud_tick(baud_tick), .adc_trig(adc_trig));
  initial forever #4 pclk = ~pclk;
  always @(posedge pclk) if (baud_tick === 1'b1) ticks <= ticks + 1;
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    chk("pready", 32'h1, 32'(pready));
    chk("pslverr", 32'(a > 8'h1C), 32'(pslverr));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic ack_pulse(input int i);
    @(posedge pclk) ack[i] <= 1'b1;
    @(posedge pclk) ack[i] <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  // Count windows allow a few cycles of bus overhead around the wait
  function automatic logic [31:0] in_win(input logic [7:0] got, input logic [7:0] e);
    logic [7:0] d;
    d = got - e + 8'h04;
    return 32'(d <= 8'h08);
  endfunction
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    $display("watchdog expired");
    print_verdict;
  end
  initial begin
    t0 = $urandom(8268);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 32'h0, "reset value");
    rd(8'h20, 32'h0, "unmapped read");
    apb(1'b1, 8'h24, $urandom);
    for (int i = 0; i < 4; i++) begin
      rv[i] = 8'($urandom);
      apb(1'b1, 8'h08 + 8'(i * 4), {24'h0, rv[i]});
      rd(8'h08 + 8'(i * 4), {24'h0, rv[i]}, "count byte");
    end
    v8 = 8'($urandom);
    apb(1'b1, 8'h18, {24'h0, v8});
    rd(8'h18, {28'h0, v8[3:0]}, "clock ctl");
    apb(1'b1, 8'h18, 32'h3);
    apb(1'b1, 8'h1C, 32'hF);
    $display("registers done");
    v8 = 8'($urandom);
    apb(1'b1, 8'h04, 32'h33);
    apb(1'b1, 8'h08, 32'hF0);
    apb(1'b1, 8'h0C, {24'h0, v8});
    apb(1'b1, 8'h00, 32'h10);
    repeat (40) @(posedge pclk);
    rd(8'h00, 32'h30, "low byte flag");
    chk("irq_t0", 32'h1, 32'(irq[0]));
    ack_pulse(0);
    chk("irq_t0 ack", 32'h0, 32'(irq[0]));
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk("low byte count", 32'h1, in_win(q[7:0], 8'h22));
    rd(8'h0C, {24'h0, v8}, "high byte idle");
    rd(8'h10, {24'h0, rv[2]}, "second timer off");
    $display("split low done");
    apb(1'b1, 8'h04, 32'h37);
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h0C, 32'hF8);
    apb(1'b1, 8'h00, 32'h50);
    sptm_pins_i.falls(2, 5);
    sptm_pins_i.falls(3, 3);
    repeat (6) @(posedge pclk);
    rd(8'h00, 32'hD0, "high byte flag");
    chk("irq_t1", 32'h1, 32'(irq[1]));
    ack_pulse(1);
    chk("irq_t1 ack", 32'h0, 32'(irq[1]));
    apb(1'b1, 8'h00, 32'h0);
    rd(8'h08, 32'h5, "event count");
    rd(8'h14, {24'h0, rv[3]}, "second high off");
    $display("split high done");
    apb(1'b1, 8'h04, 32'h3B);
    apb(1'b1, 8'h08, 32'h0);
    sptm_pins_i.hold(0, 1'b0);
    apb(1'b1, 8'h00, 32'h10);
    repeat (20) @(posedge pclk);
    rd(8'h00, 32'h12, "level flag");
    chk("irq_ext0", 32'h1, 32'(irq[2]));
    rd(8'h08, 32'h0, "gated count");
    sptm_pins_i.hold(0, 1'b1);
    repeat (20) @(posedge pclk);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk("ungated count", 32'h1, 32'(q[7:0] > 8'h0F));
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, 8'h00, 32'(1 << (2 * e)));
      sptm_pins_i.falls(e, 1);
      rd(8'h00, 32'(3 << (2 * e)), "edge flag");
      chk("ext irq", 32'h1, 32'(irq[2 + e]));
      apb(1'b1, 8'h00, 32'(1 << (2 * e)));
      rd(8'h00, 32'(1 << (2 * e)), "flag write clear");
      sptm_pins_i.falls(e, 1);
      ack_pulse(2 + e);
      rd(8'h00, 32'(1 << (2 * e)), "flag ack clear");
    end
    $display("gate and ext irq done");
    apb(1'b1, 8'h00, 32'h0);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, 8'h14, (m == 2) ? 32'hF0 : 32'hFF);
      apb(1'b1, 8'h10, 32'hF8);
      t0 = ticks;
      apb(1'b1, 8'h04, 32'(8'hC3 | (m << 4)));
      repeat (40) @(posedge pclk);
      apb(1'b1, 8'h04, 32'h33);
      chk("baud ticks", 32'h1, 32'(ticks > t0));
      rd(8'h00, 32'h0, "no second flag");
      chk("irq_t1 quiet", 32'h0, 32'(irq[1]));
      apb(1'b0, 8'h10, 32'h0);
      v8 = q[7:0];
      repeat (10) @(posedge pclk);
      rd(8'h10, {24'h0, v8}, "second halted");
    end
    $display("second timer done");
    print_verdict;
  end
endmodule
`default_nettype wire
